// *** design/timer8_tick_select.v ***
`timescale 1ns/1ps
`include "timer8_regs.vh"

module timer8_tick_select (
	input wire ref_clk,
	input wire resetSyncN,
	input wire [2:0] clockSourceSelect,
	input wire externalClockPin,
	output reg timerTick
);

	reg [`PRESCALE_W-1:0] prescaleReg;
	reg extSync1Reg;
	reg extSync2Reg;
	reg extPrevReg;
	reg tickNext;

	// ==========================================
	// free running prescaler and pin synchroniser
	always @(posedge ref_clk or negedge resetSyncN) begin
		if (!resetSyncN) begin
			prescaleReg <= {`PRESCALE_W{1'b0}};
			extSync1Reg <= 1'b0;
			extSync2Reg <= 1'b0;
			extPrevReg <= 1'b0;
			timerTick <= 1'b0;
		end else begin
			prescaleReg <= prescaleReg + {{(`PRESCALE_W-1){1'b0}}, 1'b1};
			extSync1Reg <= externalClockPin;
			extSync2Reg <= extSync1Reg;
			extPrevReg <= extSync2Reg;
			timerTick <= tickNext;
		end
	end

	// ==========================================
	// source and edge choice
	always @* begin
		case (clockSourceSelect)
			`CS_STOP: tickNext = 1'b0;
			`CS_DIV1: tickNext = 1'b1;
			`CS_DIV8: tickNext = (prescaleReg & `PRE_MASK8) == `PRE_MASK8;
			`CS_DIV64: tickNext = (prescaleReg & `PRE_MASK64) == `PRE_MASK64;
			`CS_DIV256: tickNext = (prescaleReg & `PRE_MASK256) == `PRE_MASK256;
			`CS_DIV1024: tickNext = prescaleReg == `PRE_MASK1024;
			`CS_EXT_FALL: tickNext = extPrevReg & ~extSync2Reg;
			`CS_EXT_RISE: tickNext = extSync2Reg & ~extPrevReg;
			default: tickNext = 1'b0;
		endcase
	end

endmodule // timer8_tick_select

// *** design/timer8_two_compare_pwm.v ***
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`include "timer8_regs.vh"

// Contract
// - counter and both compare registers are eight bits wide.
// - three request flags sit in one register, each gated by a mask bit.
// - tick comes from prescaler or external pin, with edge choice.
// - with no clock source the counter holds still.
// - both compare values are compared against the counter every cycle.
// - compare results drive waveforms on both compare output pins.
// - a compare match sets that unit's flag, which may interrupt.
// - bottom means the counter is zero.
// - max means the counter is all ones.
// - top is all ones or compare A, chosen by mode.
// - a three-bit clock select field in control register B picks the source.
// - compare registers are double buffered in PWM modes; other modes write them directly.
// - a mode clears the counter on compare match.
// - select zero stops the timer; counter stays readable and writable.
// - a counter write beats any clear or count in that cycle.
// - match sets flag on next tick; service or write-one clears it.
module timer8_two_compare_pwm (
	input wire ref_clk,
	input wire reset_n,
	input wire [`ADDR_W-1:0] address,
	input wire [7:0] writeData,
	input wire writeStrobe,
	input wire readStrobe,
	output reg [7:0] readData,
	input wire externalClockPin,
	input wire [`FLAG_W-1:0] irqAck,
	output reg compareAOutput,
	output reg compareAOutputEnable,
	output reg compareBOutput,
	output reg compareBOutputEnable,
	output reg irq
);

	// ==========================================
	// declarations
	reg rstSync1Reg;
	reg rstSync2Reg;
	wire resetSyncN;
	wire timerTick;
	reg [7:0] controlAReg;
	reg [2:0] clockSourceSelectReg;
	reg waveHiReg;
	reg [7:0] counterValueReg;
	reg [7:0] counterValueNext;
	reg directionDownReg;
	reg directionDownNext;
	reg [7:0] compareAValueReg;
	reg [7:0] compareBValueReg;
	reg [7:0] bufferAReg;
	reg [7:0] bufferBReg;
	reg [`FLAG_W-1:0] irqFlagReg;
	reg [`FLAG_W-1:0] irqFlagNext;
	reg [`FLAG_W-1:0] irqMaskReg;
	reg blockMatchReg;
	reg [7:0] readNext;
	wire [2:0] waveMode;
	wire pwmMode;
	wire phaseMode;
	wire topFromA;
	wire clearOnTop;
	wire [7:0] topValue;
	wire atTop;
	wire atBottom;
	wire atMax;
	wire matchA;
	wire matchB;
	wire writeCounter;
	wire writeCompareA;
	wire writeCompareB;
	wire writeCtrlB;
	wire writeFlags;
	wire compareAEvent;
	wire compareBEvent;
	wire overflowEvent;
	wire bottomEvent;
	wire bufferUpdate;
	wire forceA;
	wire forceB;
	wire [`FLAG_W-1:0] flagSet;
	wire [`FLAG_W-1:0] flagClear;

	// ==========================================
	// mode decoding
	function isPwm;
		input [2:0] mode;
		begin
			case (mode)
				`MODE_PHASE_MAX: isPwm = 1'b1;
				`MODE_FAST_MAX: isPwm = 1'b1;
				`MODE_PHASE_A: isPwm = 1'b1;
				`MODE_FAST_A: isPwm = 1'b1;
				default: isPwm = 1'b0;
			endcase
		end
	endfunction

	function isPhase;
		input [2:0] mode;
		begin
			isPhase = (mode == `MODE_PHASE_MAX) || (mode == `MODE_PHASE_A);
		end
	endfunction

	// next level of one compare output
	function waveStep;
		input current;
		input [1:0] action;
		input pwm;
		input phase;
		input downCount;
		input matchEv;
		input bottomEv;
		reg level;
		begin
			level = current;
			if (!pwm) begin
				if (matchEv) begin
					case (action)
						`OUT_TOGGLE: level = ~current;
						`OUT_CLEAR: level = 1'b0;
						`OUT_SET: level = 1'b1;
						default: level = current;
					endcase
				end
			end else if (action == `OUT_CLEAR || action == `OUT_SET) begin
				if (bottomEv && !phase) begin
					level = (action == `OUT_CLEAR);
				end
				if (matchEv) begin
					level = (action == `OUT_SET) ^ (phase && downCount);
				end
			end
			waveStep = level;
		end
	endfunction

	// ==========================================
	// reset release
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rstSync1Reg <= 1'b0;
			rstSync2Reg <= 1'b0;
		end else begin
			rstSync1Reg <= 1'b1;
			rstSync2Reg <= rstSync1Reg;
		end
	end

	assign resetSyncN = rstSync2Reg;

	// ==========================================
	// timer tick
	timer8_tick_select tickSelect (
		.ref_clk(ref_clk),
		.resetSyncN(resetSyncN),
		.clockSourceSelect(clockSourceSelectReg),
		.externalClockPin(externalClockPin),
		.timerTick(timerTick)
	);

	// ==========================================
	// counter state decode
	assign waveMode = {waveHiReg, controlAReg[`CTRL_A_WAVE]};
	assign pwmMode = isPwm(waveMode);
	assign phaseMode = isPhase(waveMode);
	assign topFromA = (waveMode == `MODE_CTC) || waveMode == `MODE_PHASE_A
		|| waveMode == `MODE_FAST_A;
	assign clearOnTop = (waveMode == `MODE_CTC) || (waveMode == `MODE_FAST_MAX)
		|| (waveMode == `MODE_FAST_A);
	assign topValue = topFromA ? compareAValueReg : `COUNT_MAX;
	assign atTop = counterValueReg == topValue;
	assign atBottom = counterValueReg == `COUNT_BOTTOM;
	assign atMax = counterValueReg == `COUNT_MAX;
	assign matchA = counterValueReg == compareAValueReg;
	assign matchB = counterValueReg == compareBValueReg;

	// ==========================================
	// bus decode
	assign writeCounter = writeStrobe && address == `ADDR_COUNTER;
	assign writeCompareA = writeStrobe && address == `ADDR_COMPARE_A;
	assign writeCompareB = writeStrobe && address == `ADDR_COMPARE_B;
	assign writeCtrlB = writeStrobe && address == `ADDR_CTRL_B;
	assign writeFlags = writeStrobe && address == `ADDR_IRQ_FLAG;
	assign forceA = writeCtrlB && writeData[`CTRL_B_FORCE_A] && !pwmMode;
	assign forceB = writeCtrlB && writeData[`CTRL_B_FORCE_B] && !pwmMode;

	// ==========================================
	// events
	assign compareAEvent = timerTick && matchA && !blockMatchReg;
	assign compareBEvent = timerTick && matchB && !blockMatchReg;
	assign bottomEvent = timerTick && !phaseMode && clearOnTop && atTop;
	assign overflowEvent = timerTick && (phaseMode ? (directionDownReg && atBottom)
		: (clearOnTop && waveMode != `MODE_CTC ? atTop : atMax));
	assign bufferUpdate = timerTick && pwmMode
		&& (phaseMode ? (!directionDownReg && atTop) : atTop);

	// ==========================================
	// count sequence
	always @* begin
		counterValueNext = counterValueReg;
		directionDownNext = directionDownReg;
		if (timerTick) begin
			if (phaseMode) begin
				if (!directionDownReg) begin
					if (atTop) begin
						directionDownNext = 1'b1;
						counterValueNext = counterValueReg - `COUNT_STEP;
					end else begin
						counterValueNext = counterValueReg + `COUNT_STEP;
					end
				end else begin
					if (atBottom) begin
						directionDownNext = 1'b0;
						counterValueNext = counterValueReg + `COUNT_STEP;
					end else begin
						counterValueNext = counterValueReg - `COUNT_STEP;
					end
				end
			end else if (clearOnTop && atTop) begin
				counterValueNext = `COUNT_BOTTOM;
			end else begin
				counterValueNext = counterValueReg + `COUNT_STEP;
			end
		end
		if (!phaseMode) begin
			directionDownNext = 1'b0;
		end
		if (writeCounter) begin
			counterValueNext = writeData;
		end
	end

	// ==========================================
	// flags: a set in the same cycle as its clear wins
	assign flagSet = {compareBEvent, compareAEvent, overflowEvent};
	assign flagClear = (writeFlags ? writeData[`FLAG_W-1:0] : `RST_FLAGS)
		| irqAck;

	always @* begin
		irqFlagNext = (irqFlagReg & ~flagClear) | flagSet;
	end

	// ==========================================
	// read mux
	always @* begin
		case (address)
			`ADDR_CTRL_A: readNext = controlAReg;
			`ADDR_CTRL_B: readNext = {4'h0, waveHiReg, clockSourceSelectReg};
			`ADDR_COUNTER: readNext = counterValueReg;
			`ADDR_COMPARE_A: readNext = bufferAReg;
			`ADDR_COMPARE_B: readNext = bufferBReg;
			`ADDR_IRQ_FLAG: readNext = {5'h00, irqFlagReg};
			`ADDR_IRQ_MASK: readNext = {5'h00, irqMaskReg};
			default: readNext = `RST_BYTE;
		endcase
		if (!readStrobe) begin
			readNext = `RST_BYTE;
		end
	end

	// ==========================================
	// registers
	always @(posedge ref_clk or negedge resetSyncN) begin
		if (!resetSyncN) begin
			controlAReg <= `RST_BYTE;
			clockSourceSelectReg <= `RST_CLKSEL;
			waveHiReg <= 1'b0;
			counterValueReg <= `RST_BYTE;
			directionDownReg <= 1'b0;
			compareAValueReg <= `RST_BYTE;
			compareBValueReg <= `RST_BYTE;
			bufferAReg <= `RST_BYTE;
			bufferBReg <= `RST_BYTE;
			irqFlagReg <= `RST_FLAGS;
			irqMaskReg <= `RST_FLAGS;
			blockMatchReg <= 1'b0;
			readData <= `RST_BYTE;
			compareAOutput <= 1'b0;
			compareBOutput <= 1'b0;
			compareAOutputEnable <= 1'b0;
			compareBOutputEnable <= 1'b0;
			irq <= 1'b0;
		end else begin
			if (writeStrobe && address == `ADDR_CTRL_A) begin
				controlAReg <= writeData;
			end
			if (writeCtrlB) begin
				clockSourceSelectReg <= writeData[`CTRL_B_CLKSEL];
				waveHiReg <= writeData[`CTRL_B_WAVE_HI];
			end
			if (writeStrobe && address == `ADDR_IRQ_MASK) begin
				irqMaskReg <= writeData[`FLAG_W-1:0];
			end
			counterValueReg <= counterValueNext;
			directionDownReg <= directionDownNext;
			if (writeCounter) begin
				blockMatchReg <= 1'b1;
			end else if (timerTick) begin
				blockMatchReg <= 1'b0;
			end
			if (writeCompareA) begin
				bufferAReg <= writeData;
			end
			if (writeCompareB) begin
				bufferBReg <= writeData;
			end
			if (!pwmMode && writeCompareA) begin
				compareAValueReg <= writeData;
			end else if (bufferUpdate) begin
				compareAValueReg <= bufferAReg;
			end
			if (!pwmMode && writeCompareB) begin
				compareBValueReg <= writeData;
			end else if (bufferUpdate) begin
				compareBValueReg <= bufferBReg;
			end
			irqFlagReg <= irqFlagNext;
			irq <= |(irqFlagReg & irqMaskReg);
			readData <= readNext;
			compareAOutput <= waveStep(compareAOutput, controlAReg[`CTRL_A_OUT_A],
				pwmMode, phaseMode, directionDownReg,
				compareAEvent || forceA, bottomEvent);
			compareBOutput <= waveStep(compareBOutput, controlAReg[`CTRL_A_OUT_B],
				pwmMode, phaseMode, directionDownReg,
				compareBEvent || forceB, bottomEvent);
			compareAOutputEnable <= controlAReg[`CTRL_A_OUT_A] != `OUT_OFF;
			compareBOutputEnable <= controlAReg[`CTRL_A_OUT_B] != `OUT_OFF;
		end
	end

endmodule // timer8_two_compare_pwm

// *** dv/test_timer8_two_compare_pwm.sv ***
`timescale 1ns/1ps
`include "timer8_regs.vh"
`define CHK(nm, e, g) begin testsRun++; if ((g) !== (e)) begin errTotal++; \
	$display("ERROR %s exp %h got %h", nm, e, g); end end
module test_timer8_two_compare_pwm;
	logic ref_clk, reset_n, writeStrobe, readStrobe, externalClockPin;
	logic [2:0] address, irqAck;
	logic [7:0] writeData, readData, rv;
	logic compareAOutput, compareAOutputEnable, compareBOutput, compareBOutputEnable, irq, v, w;
	int errTotal = 0;
	int testsRun = 0;
	timer8_two_compare_pwm dut (.ref_clk(ref_clk), .reset_n(reset_n), .address(address),
		.writeData(writeData), .writeStrobe(writeStrobe), .readStrobe(readStrobe),
		.readData(readData), .externalClockPin(externalClockPin), .irqAck(irqAck),
		.compareAOutput(compareAOutput), .compareAOutputEnable(compareAOutputEnable),
		.compareBOutput(compareBOutput), .compareBOutputEnable(compareBOutputEnable), .irq(irq));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// ==========================================
	// bus and helper tasks
	task automatic wr(input [2:0] a, input [7:0] d);
		@(posedge ref_clk);
		writeStrobe <= 1'b1; address <= a; writeData <= d;
		@(posedge ref_clk);
		writeStrobe <= 1'b0;
	endtask
	task automatic rd(input [2:0] a);
		@(posedge ref_clk);
		readStrobe <= 1'b1; address <= a;
		@(posedge ref_clk);
		readStrobe <= 1'b0;
		#1 rv = readData;
	endtask
	task automatic completeRun;
		if (errTotal == 0 && testsRun > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic waitIrq(input int n);
		int i;
		for (i = 0; i < n && irq !== 1'b1; i++) begin
			@(posedge ref_clk);
			#1;
		end
		if (irq !== 1'b1) begin
			errTotal++;
			completeRun();
		end
	endtask
	// ==========================================
	// scenarios
	task automatic resetValues;
		int a;
		for (a = 2; a < 8; a++) begin
			rd(a[2:0]);
			`CHK("reset value", 8'h00, rv)
		end
		wr(3'h7, 8'hFF);
		rd(3'h7);
		`CHK("unmapped", 8'h00, rv)
	endtask
	task automatic stoppedCounter;
		wr(`ADDR_CTRL_B, `CS_STOP);
		wr(`ADDR_COUNTER, 8'h55);
		repeat (10) @(posedge ref_clk);
		rd(`ADDR_COUNTER);
		`CHK("stopped counter", 8'h55, rv)
	endtask
	task automatic compareFlags;
		wr(`ADDR_IRQ_MASK, 8'h06);
		wr(`ADDR_COMPARE_A, 8'h03);
		wr(`ADDR_COMPARE_B, 8'h02);
		wr(`ADDR_COUNTER, 8'h00);
		wr(`ADDR_CTRL_B, `CS_DIV1);
		waitIrq(20);
		wr(`ADDR_CTRL_B, `CS_STOP);
		rd(`ADDR_IRQ_FLAG);
		`CHK("compare flags", 8'h06, rv)
		wr(`ADDR_IRQ_MASK, 8'h00);
		rd(`ADDR_IRQ_FLAG);
		`CHK("masked irq", 1'b0, irq)
		wr(`ADDR_IRQ_FLAG, 8'h06);
		rd(`ADDR_IRQ_FLAG);
		`CHK("flag clear", 8'h00, rv)
	endtask
	task automatic overflowAck;
		wr(`ADDR_COUNTER, 8'hFE);
		wr(`ADDR_IRQ_MASK, 8'h01);
		wr(`ADDR_CTRL_B, `CS_DIV1);
		waitIrq(10);
		wr(`ADDR_CTRL_B, `CS_STOP);
		rd(`ADDR_IRQ_FLAG);
		`CHK("overflow flag", 1'b1, rv[0])
		@(posedge ref_clk) irqAck <= 3'h1;
		@(posedge ref_clk) irqAck <= 3'h0;
		rd(`ADDR_IRQ_FLAG);
		`CHK("ack clear", 1'b0, rv[0])
		`CHK("irq after ack", 1'b0, irq)
	endtask
	task automatic clearOnCompare;
		wr(`ADDR_IRQ_FLAG, 8'h07);
		wr(`ADDR_CTRL_A, 8'h02);
		wr(`ADDR_COMPARE_A, 8'h05);
		wr(`ADDR_COUNTER, 8'h00);
		wr(`ADDR_CTRL_B, `CS_DIV1);
		repeat (40) @(posedge ref_clk);
		wr(`ADDR_CTRL_B, `CS_STOP);
		rd(`ADDR_COUNTER);
		`CHK("ctc wrap", 1'b1, rv <= 8'h05)
		rd(`ADDR_IRQ_FLAG);
		`CHK("ctc no overflow", 2'b10, rv[1:0])
		wr(`ADDR_CTRL_A, 8'h00);
	endtask
	task automatic externalClock;
		int k;
		for (k = 0; k < 2; k++) begin
			wr(`ADDR_COUNTER, 8'h00);
			wr(`ADDR_CTRL_B, k ? `CS_EXT_RISE : `CS_EXT_FALL);
			repeat (3) begin
				@(posedge ref_clk) externalClockPin <= 1'b1;
				repeat (8) @(posedge ref_clk);
				externalClockPin <= 1'b0;
				repeat (8) @(posedge ref_clk);
			end
			wr(`ADDR_CTRL_B, `CS_STOP);
			rd(`ADDR_COUNTER);
			`CHK("external edges", 8'h03, rv)
		end
	endtask
	task automatic forceToggle;
		wr(`ADDR_CTRL_A, 8'h50);
		repeat (2) @(posedge ref_clk);
		`CHK("output a enable", 1'b1, compareAOutputEnable)
		`CHK("output b enable", 1'b1, compareBOutputEnable)
		v = compareAOutput;
		w = compareBOutput;
		wr(`ADDR_CTRL_B, 8'hC0);
		rd(`ADDR_CTRL_B);
		`CHK("force bits read", 8'h00, rv)
		rd(`ADDR_CTRL_A);
		`CHK("control a", 8'h50, rv)
		`CHK("forced toggle a", ~v, compareAOutput)
		`CHK("forced toggle b", ~w, compareBOutput)
	endtask
	task automatic pwmBuffer;
		wr(`ADDR_IRQ_FLAG, 8'h07);
		wr(`ADDR_CTRL_A, 8'h83);
		wr(`ADDR_COUNTER, 8'h10);
		wr(`ADDR_COMPARE_A, 8'h20);
		rd(`ADDR_COMPARE_A);
		`CHK("buffer readback", 8'h20, rv)
		wr(`ADDR_CTRL_B, `CS_DIV1);
		repeat (100) @(posedge ref_clk);
		rd(`ADDR_IRQ_FLAG);
		`CHK("held compare", 3'h0, rv[2:0])
		repeat (200) @(posedge ref_clk);
		rd(`ADDR_IRQ_FLAG);
		`CHK("loaded compare", 3'h7, rv[2:0])
		`CHK("pwm level", 1'b0, compareAOutput)
		wr(`ADDR_CTRL_B, `CS_STOP);
		wr(`ADDR_CTRL_A, 8'h00);
	endtask
	initial begin
		reset_n = 1'b0; writeStrobe = 1'b0; readStrobe = 1'b0; address = 3'h0;
		writeData = 8'h00; externalClockPin = 1'b0; irqAck = 3'h0;
		repeat (20) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (5) @(posedge ref_clk);
		resetValues();
		stoppedCounter();
		compareFlags();
		overflowAck();
		clearOnCompare();
		externalClock();
		forceToggle();
		pwmBuffer();
		completeRun();
	end
endmodule // test_timer8_two_compare_pwm

// *** dv/timer8_two_compare_pwm_chk.sv ***
`timescale 1ns/1ps
module timer8_two_compare_pwm_chk (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [2:0] address,
	input wire logic [7:0] writeData,
	input wire logic writeStrobe,
	input wire logic readStrobe,
	input wire logic [7:0] readData,
	input wire logic compareAOutput,
	input wire logic compareAOutputEnable,
	input wire logic compareBOutputEnable,
	input wire logic irq
);
	// ==========================================
	// shadows of software-written state
	logic [7:0] ctrlAReg;
	logic [2:0] maskReg;
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrlAReg <= 8'h00;
			maskReg <= 3'h0;
		end else if (writeStrobe) begin
			if (address == 3'h0) ctrlAReg <= writeData;
			if (address == 3'h6) maskReg <= writeData[2:0];
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	// ==========================================
	// properties
	property p_rd_idle;
		!$past(readStrobe) |-> readData == 8'h00;
	endproperty
	property p_rd_unmapped;
		$past(readStrobe && address == 3'h7) |-> readData == 8'h00;
	endproperty
	property p_rd_mask;
		$past(readStrobe && address == 3'h6) |-> readData[2:0] == $past(maskReg);
	endproperty
	property p_rd_ctrl_a;
		$past(readStrobe && address == 3'h0) |-> (readData & 8'hF3) == ($past(ctrlAReg) & 8'hF3);
	endproperty
	property p_rd_force;
		$past(readStrobe && address == 3'h1) |-> readData[7:6] == 2'h0;
	endproperty
	property p_oe_a;
		compareAOutputEnable == ($past(ctrlAReg[7:6]) != 2'h0);
	endproperty
	property p_oe_b;
		compareBOutputEnable == ($past(ctrlAReg[5:4]) != 2'h0);
	endproperty
	property p_irq_masked;
		$past(maskReg) == 3'h0 |-> !irq;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
	a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
	a_rd_mask: assert property (p_rd_mask) else $error("mask readback wrong");
	a_rd_ctrl_a: assert property (p_rd_ctrl_a) else $error("control a readback wrong");
	a_rd_force: assert property (p_rd_force) else $error("force bits read nonzero");
	a_oe_a: assert property (p_oe_a) else $error("output a enable wrong");
	a_oe_b: assert property (p_oe_b) else $error("output b enable wrong");
	a_irq_masked: assert property (p_irq_masked) else $error("irq with mask clear");
	c_irq: cover property ($rose(irq));
	c_out_a: cover property ($changed(compareAOutput));
	c_unmapped: cover property ($past(readStrobe && address == 3'h7));
endmodule // timer8_two_compare_pwm_chk
bind timer8_two_compare_pwm timer8_two_compare_pwm_chk chk (.ref_clk(ref_clk),
	.reset_n(reset_n), .address(address), .writeData(writeData), .writeStrobe(writeStrobe),
	.readStrobe(readStrobe), .readData(readData), .compareAOutput(compareAOutput),
	.compareAOutputEnable(compareAOutputEnable), .compareBOutputEnable(compareBOutputEnable),
	.irq(irq));

// *** pkg/timer8_regs.vh ***
`ifndef TIMER8_REGS_VH
`define TIMER8_REGS_VH

// ==========================================
// register map
`define ADDR_W 3
`define ADDR_CTRL_A 3'h0
`define ADDR_CTRL_B 3'h1
`define ADDR_COUNTER 3'h2
`define ADDR_COMPARE_A 3'h3
`define ADDR_COMPARE_B 3'h4
`define ADDR_IRQ_FLAG 3'h5
`define ADDR_IRQ_MASK 3'h6

// ==========================================
// fields
`define CTRL_A_WAVE 1:0
`define CTRL_A_OUT_B 5:4
`define CTRL_A_OUT_A 7:6
`define CTRL_B_CLKSEL 2:0
`define CTRL_B_WAVE_HI 3
`define CTRL_B_FORCE_B 6
`define CTRL_B_FORCE_A 7
`define FLAG_OVERFLOW 0
`define FLAG_COMPARE_A 1
`define FLAG_COMPARE_B 2
`define FLAG_W 3

// ==========================================
// reset values
`define RST_BYTE 8'h00
`define RST_FLAGS 3'h0
`define RST_CLKSEL 3'h0

// ==========================================
// counter limits
`define COUNT_BOTTOM 8'h00
`define COUNT_MAX 8'hFF
`define COUNT_STEP 8'h01

// ==========================================
// clock source select codes
`define CS_STOP 3'h0
`define CS_DIV1 3'h1
`define CS_DIV8 3'h2
`define CS_DIV64 3'h3
`define CS_DIV256 3'h4
`define CS_DIV1024 3'h5
`define CS_EXT_FALL 3'h6
`define CS_EXT_RISE 3'h7
`define PRESCALE_W 10
`define PRE_MASK8 10'h007
`define PRE_MASK64 10'h03F
`define PRE_MASK256 10'h0FF
`define PRE_MASK1024 10'h3FF

// ==========================================
// waveform modes
`define MODE_NORMAL 3'h0
`define MODE_PHASE_MAX 3'h1
`define MODE_CTC 3'h2
`define MODE_FAST_MAX 3'h3
`define MODE_PHASE_A 3'h5
`define MODE_FAST_A 3'h7

// ==========================================
// compare output actions
`define OUT_OFF 2'h0
`define OUT_TOGGLE 2'h1
`define OUT_CLEAR 2'h2
`define OUT_SET 2'h3

`endif
